// >>> src/trb_pkg.sv
// constants, types and helpers shared by both ends of the serial bridge
package trb_pkg;
  // ---------------------------------------------------------------
  // clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int BAUD        = 115200;
  localparam int BAUD_DIV    = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int IDLE_GAP_MS = 20;
  localparam int IDLE_GAP_CYC = (CLK_HZ / 1000) * IDLE_GAP_MS;
  localparam logic [9:0] BAUD_DIV_M1 = 10'(BAUD_DIV - 1);
  localparam logic [9:0] BAUD_HALF   = 10'(BAUD_DIV / 2);
  localparam logic [3:0] UART_FRAME  = 4'hA;
  localparam logic [3:0] UART_STOP   = 4'h9;
  localparam logic [1:0] MODE_WAIT   = 2'h3;
  // ---------------------------------------------------------------
  // payload sizes
  // ---------------------------------------------------------------
  localparam int PAY_MAX = 243;
  localparam int MTU_MAX = 247;
  localparam logic [7:0] PAY_MAX_B = 8'hF3;
  localparam logic [7:0] PAY_DEF   = 8'h13;
  // ---------------------------------------------------------------
  // security and advertising defaults
  // ---------------------------------------------------------------
  localparam logic [19:0] PASSKEY_DEF  = 20'h1E0F3;
  localparam logic [7:0]  PER_SEC_DEF  = 8'h0B;
  localparam logic [7:0]  NAME_LETTER  = 8'h41;
  localparam logic [7:0]  NAME_DASH    = 8'h2D;
  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_TXDATA = 8'h08;
  localparam logic [7:0]  REG_RXDATA = 8'h0C;
  localparam logic [7:0]  REG_LIMIT  = 8'h10;
  localparam logic        CTRL_RST   = 1'b1;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_CMD  = 2'b01,
    ST_ADV  = 2'b10,
    ST_OPEN = 2'b11
  } trb_state_e;
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
endpackage

// >>> src/trb_if.sv
// serial link and strap pins between host controller and radio bridge
interface trb_if;
  logic operating_mode_select_pin;
  logic channel_open_indicator;
  logic ser_h2d;
  logic ser_d2h;
  modport dev (
    input  operating_mode_select_pin,
    input  ser_h2d,
    output channel_open_indicator,
    output ser_d2h
  );
  modport host (
    output operating_mode_select_pin,
    output ser_h2d,
    input  channel_open_indicator,
    input  ser_d2h
  );
endinterface

// >>> src/trb_dev.sv
// radio bridge end: peripheral-only transparent serial to air bridge
// Summary of operation
// [R01] mode pin high at reset selects peripheral-only
// [R02] advertise until connect; serial on when open
// [R03] serial port disabled again on disconnect
// [R04] indicator on when open, off when closed
// [R05] never scan nor initiate connections
// [R06] air bytes go to host without headers
// [R07] serial input is payload only, no commands
// [R08] at most one packet per connection interval
// [R09] serial format 115200 baud 8n1
// [R10] static passkey 123123, bonding on
// [R11] payload up to 243 bytes, MTU 247
// [R12] no MTU request means 19 byte payload
// [R13] bytes beyond payload limit are discarded
// [R14] limit and discards never reported to host
// [R15] host sends at most 19 bytes first
// [R16] buffer input, send after 20 ms idle
// [R17] name is letter, hyphen, six MAC digits
// [R18] advertising omits transmit power block
// [R19] settings change only in command mode
// [R20] serial bytes while closed are dropped
module trb_dev #(
  parameter int          IDLE_GAP = trb_pkg::IDLE_GAP_CYC,
  parameter logic [19:0] PASSKEY  = trb_pkg::PASSKEY_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  trb_if.dev               lnk,
  input  wire logic [47:0] radio_mac_address,
  input  wire logic        central_connect,
  input  wire logic        central_disconnect,
  input  wire logic        mtu_req,
  input  wire logic [7:0]  mtu_payload,
  input  wire logic        conn_event,
  input  wire logic        air_rx_valid,
  input  wire logic [7:0]  air_rx_data,
  output logic             air_rx_ready,
  output logic             air_tx_valid,
  output logic [7:0]       air_tx_data,
  output logic             air_tx_last,
  input  wire logic        air_tx_ready,
  output logic             advertising,
  output logic             peripheral_mode,
  output logic             central_role_allowed,
  output logic             adv_txpower_included,
  output logic [63:0]      adv_name,
  output logic [19:0]      fixed_pairing_key,
  output logic [7:0]       peripheral_security_setting,
  output logic             bonding_enabled
);
  import trb_pkg::*;

  localparam int GW = $clog2(IDLE_GAP + 1);
  if (IDLE_GAP < 1) begin : g_chk
    $error("IDLE_GAP must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // pin synchronisers and start-up strap
  // ---------------------------------------------------------------
  logic [1:0]  mode_sync;
  logic [1:0]  rx_sync;
  logic [1:0]  init_cnt;
  trb_state_e  state;
  trb_state_e  next_state;
  logic        open;
  logic        init_done;
  logic [63:0] name_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sync <= 2'h0;
      rx_sync   <= 2'h3;
    end else begin
      mode_sync <= {mode_sync[0], lnk.operating_mode_select_pin};
      rx_sync   <= {rx_sync[0], lnk.ser_h2d};
    end
  end

  assign init_done = (init_cnt == MODE_WAIT);
  assign open      = (state == ST_OPEN);

  always_comb begin
    name_w[63:48] = {NAME_LETTER, NAME_DASH};
    for (int i = 0; i < 6; i++) begin
      name_w[8*i +: 8] = hex_char(radio_mac_address[4*i +: 4]); // [R17]
    end
  end

  // ---------------------------------------------------------------
  // connection state
  // ---------------------------------------------------------------
  // command mode is inert here; configuration lives elsewhere
  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT: begin
        if (init_done) begin
          next_state = mode_sync[1] ? ST_ADV : ST_CMD; // [R01]
        end
      end
      ST_CMD: begin
        next_state = ST_CMD; // [R19]
      end
      ST_ADV: begin
        if (central_connect) begin
          next_state = ST_OPEN; // [R02]
        end
      end
      ST_OPEN: begin
        if (central_disconnect) begin
          next_state = ST_ADV; // [R03]
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                       <= ST_INIT;
      init_cnt                    <= 2'h0;
      advertising                 <= 1'b0;
      peripheral_mode             <= 1'b0;
      central_role_allowed        <= 1'b0;
      adv_txpower_included        <= 1'b0;
      adv_name                    <= 64'h0;
      fixed_pairing_key           <= PASSKEY_DEF;
      peripheral_security_setting <= PER_SEC_DEF;
      bonding_enabled             <= 1'b1;
      lnk.channel_open_indicator  <= 1'b0;
    end else begin
      state    <= next_state;
      advertising <= (next_state == ST_ADV); // [R02]
      lnk.channel_open_indicator <= (next_state == ST_OPEN); // [R04]
      if (!init_done) begin
        init_cnt <= init_cnt + 2'h1;
      end
      if (state == ST_INIT && init_done) begin
        peripheral_mode      <= mode_sync[1]; // [R01]
        central_role_allowed <= !mode_sync[1]; // [R05]
        adv_txpower_included <= !mode_sync[1]; // [R18]
        adv_name             <= name_w; // [R17]
        fixed_pairing_key    <= PASSKEY; // [R10]
        bonding_enabled      <= 1'b1; // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // serial receiver, runs only while the channel is open
  // ---------------------------------------------------------------
  logic [9:0] rx_cnt;
  logic [3:0] rx_bit;
  logic       rx_busy;
  logic       rx_done;
  logic [7:0] rx_sh;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt  <= 10'h0;
      rx_bit  <= 4'h0;
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_sh   <= 8'h00;
    end else if (!open) begin
      rx_busy <= 1'b0; // [R20]
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_sync[1]) begin
          rx_busy <= 1'b1;
          rx_cnt  <= BAUD_HALF; // [R09]
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 10'h0) begin
        rx_cnt <= rx_cnt - 10'h1;
      end else begin
        rx_cnt <= BAUD_DIV_M1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_sync[1]) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == UART_STOP) begin
          rx_busy <= 1'b0;
          rx_done <= rx_sync[1]; // [R09]
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rx_sync[1], rx_sh[7:1]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // payload buffer and packet sender
  // ---------------------------------------------------------------
  logic [7:0]    buf_mem [PAY_MAX];
  logic [7:0]    buf_cnt;
  logic [7:0]    rd_ptr;
  logic [7:0]    pay_lim;
  logic [GW-1:0] gap_cnt;
  logic          pend;
  logic          snd;
  logic          store;
  logic          tx_take;
  logic [7:0]    lim_req;

  // every byte is payload; nothing is parsed as a command
  // drops are silent: no status path back to the host [R14]
  assign store   = rx_done && !pend && (buf_cnt < pay_lim); // [R07] [R13]
  assign tx_take = air_tx_valid && air_tx_ready;
  assign lim_req = (mtu_payload > PAY_MAX_B) ? PAY_MAX_B :
                   (mtu_payload < PAY_DEF) ? PAY_DEF : mtu_payload; // [R11]

  always_ff @(posedge hclk) begin
    if (store) begin
      buf_mem[buf_cnt] <= rx_sh; // [R16]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_cnt      <= 8'h00;
      rd_ptr       <= 8'h00;
      pay_lim      <= PAY_DEF;
      gap_cnt      <= '0;
      pend         <= 1'b0;
      snd          <= 1'b0;
      air_tx_valid <= 1'b0;
      air_tx_data  <= 8'h00;
      air_tx_last  <= 1'b0;
    end else if (!open) begin
      // a closed channel flushes nothing and keeps nothing
      buf_cnt      <= 8'h00; // [R20]
      pend         <= 1'b0;
      snd          <= 1'b0;
      air_tx_valid <= 1'b0;
      pay_lim      <= PAY_DEF; // [R12]
    end else begin
      if (mtu_req) begin
        pay_lim <= lim_req; // [R11]
      end
      if (store) begin
        buf_cnt <= buf_cnt + 8'h01;
        gap_cnt <= GW'(IDLE_GAP); // [R16]
      end else if (gap_cnt != '0) begin
        gap_cnt <= gap_cnt - GW'(1);
      end
      if (!pend && buf_cnt != 8'h00 &&
          (buf_cnt >= pay_lim || (gap_cnt == '0 && !store))) begin
        pend <= 1'b1; // [R16]
      end
      if (pend && !snd && conn_event) begin
        snd    <= 1'b1; // [R08]
        rd_ptr <= 8'h00;
      end
      if (snd && (!air_tx_valid || tx_take)) begin
        if (tx_take && air_tx_last) begin
          air_tx_valid <= 1'b0;
          snd          <= 1'b0;
          pend         <= 1'b0;
          buf_cnt      <= 8'h00;
        end else begin
          air_tx_valid <= 1'b1;
          air_tx_data  <= buf_mem[rd_ptr];
          air_tx_last  <= (rd_ptr == buf_cnt - 8'h01);
          rd_ptr       <= rd_ptr + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // serial transmitter toward the host
  // ---------------------------------------------------------------
  logic [9:0] tx_cnt;
  logic [3:0] tx_bits;
  logic [8:0] tx_sh;
  logic       rx_take;

  assign rx_take = air_rx_valid && air_rx_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt       <= 10'h0;
      tx_bits      <= 4'h0;
      tx_sh        <= 9'h1FF;
      air_rx_ready <= 1'b0;
      lnk.ser_d2h  <= 1'b1;
    end else if (!open) begin
      tx_bits      <= 4'h0; // [R03]
      air_rx_ready <= 1'b0;
      lnk.ser_d2h  <= 1'b1;
    end else if (rx_take) begin
      air_rx_ready <= 1'b0;
      tx_sh        <= {1'b1, air_rx_data}; // [R06]
      tx_bits      <= UART_FRAME;
      tx_cnt       <= BAUD_DIV_M1;
      lnk.ser_d2h  <= 1'b0;
    end else if (tx_bits == 4'h0) begin
      air_rx_ready <= 1'b1;
    end else if (tx_cnt != 10'h0) begin
      tx_cnt <= tx_cnt - 10'h1;
    end else begin
      tx_cnt  <= BAUD_DIV_M1; // [R09]
      tx_bits <= tx_bits - 4'h1;
      if (tx_bits != 4'h1) begin
        lnk.ser_d2h <= tx_sh[0];
        tx_sh       <= {1'b1, tx_sh[8:1]};
      end
    end
  end
endmodule

// >>> src/trb_host.sv
// host controller end: AHB-Lite registers driving the bridge serial link
module trb_host #(
  parameter int IDLE_GAP = trb_pkg::IDLE_GAP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  trb_if.host              lnk,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import trb_pkg::*;

  localparam int GW = $clog2(IDLE_GAP + 1);
  if (IDLE_GAP < 1) begin : g_chk
    $error("IDLE_GAP must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // link synchronisers
  // ---------------------------------------------------------------
  logic [1:0] open_sync;
  logic [1:0] rx_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_sync <= 2'h0;
      rx_sync   <= 2'h3;
    end else begin
      open_sync <= {open_sync[0], lnk.channel_open_indicator};
      rx_sync   <= {rx_sync[0], lnk.ser_d2h};
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic          acc;
  logic          wr_pend;
  logic [7:0]    wr_addr;
  logic [31:0]   rd_mux;
  logic          rx_pop;
  logic          tx_go;
  logic          tx_idle;
  logic          burst_full;
  logic [7:0]    burst_cnt;
  logic [7:0]    burst_lim;
  logic [GW-1:0] gap_cnt;
  logic [7:0]    rx_data;
  logic          rx_valid;
  logic          rx_ovr;
  logic          rx_done;
  logic [7:0]    rx_sh;
  logic [3:0]    tx_bits;

  assign acc        = hsel && htrans[1] && hready;
  assign rx_pop     = acc && !hwrite && (haddr[7:0] == REG_RXDATA);
  assign tx_idle    = (tx_bits == 4'h0);
  // first packets must fit the smallest payload until told otherwise
  assign burst_full = (burst_cnt >= burst_lim); // [R15]
  assign tx_go      = wr_pend && (wr_addr == REG_TXDATA) && open_sync[1] &&
                      tx_idle && !burst_full;
  assign rd_mux =
    (haddr[7:0] == REG_CTRL)   ? {31'h0, lnk.operating_mode_select_pin} :
    (haddr[7:0] == REG_STATUS) ? {28'h0, rx_ovr, rx_valid, !tx_idle,
                                  open_sync[1]} :
    (haddr[7:0] == REG_RXDATA) ? {24'h0, rx_data} :
    (haddr[7:0] == REG_LIMIT)  ? {24'h0, burst_lim} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      burst_lim <= PAY_DEF;
      lnk.operating_mode_select_pin <= CTRL_RST; // [R01]
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend && wr_addr == REG_CTRL) begin
        lnk.operating_mode_select_pin <= hwdata[0]; // [R19]
      end
      if (wr_pend && wr_addr == REG_LIMIT) begin
        burst_lim <= (hwdata[7:0] > PAY_MAX_B) ? PAY_MAX_B : hwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // serial transmitter and burst limit
  // ---------------------------------------------------------------
  logic [9:0] tx_cnt;
  logic [8:0] tx_sh;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt      <= 10'h0;
      tx_bits     <= 4'h0;
      tx_sh       <= 9'h1FF;
      burst_cnt   <= 8'h00;
      gap_cnt     <= '0;
      lnk.ser_h2d <= 1'b1;
    end else begin
      if (tx_go) begin
        tx_sh       <= {1'b1, hwdata[7:0]}; // [R09]
        tx_bits     <= UART_FRAME;
        tx_cnt      <= BAUD_DIV_M1;
        lnk.ser_h2d <= 1'b0;
        burst_cnt   <= burst_cnt + 8'h01; // [R15]
        gap_cnt     <= GW'(IDLE_GAP);
      end else begin
        if (!tx_idle) begin
          if (tx_cnt != 10'h0) begin
            tx_cnt <= tx_cnt - 10'h1;
          end else begin
            tx_cnt  <= BAUD_DIV_M1;
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits != 4'h1) begin
              lnk.ser_h2d <= tx_sh[0];
              tx_sh       <= {1'b1, tx_sh[8:1]};
            end
          end
        end else if (gap_cnt != '0) begin
          gap_cnt <= gap_cnt - GW'(1);
        end else begin
          burst_cnt <= 8'h00;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // serial receiver
  // ---------------------------------------------------------------
  logic [9:0] rx_cnt;
  logic [3:0] rx_bit;
  logic       rx_busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt  <= 10'h0;
      rx_bit  <= 4'h0;
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_sh   <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_sync[1]) begin
          rx_busy <= 1'b1;
          rx_cnt  <= BAUD_HALF;
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != 10'h0) begin
        rx_cnt <= rx_cnt - 10'h1;
      end else begin
        rx_cnt <= BAUD_DIV_M1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_sync[1]) begin
          rx_busy <= 1'b0;
        end else if (rx_bit == UART_STOP) begin
          rx_busy <= 1'b0;
          rx_done <= rx_sync[1];
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rx_sync[1], rx_sh[7:1]};
        end
      end
    end
  end

  // new byte wins over a pop in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
    end else if (rx_done) begin
      rx_data  <= rx_sh;
      rx_valid <= 1'b1;
      rx_ovr   <= rx_ovr || (rx_valid && !rx_pop);
    end else if (rx_pop) begin
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
    end
  end
endmodule

// >>> testbench/trb_asserts.sv
// concurrent checks on the link and the bridge end of the serial bridge
module trb_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        channel_open_indicator,
  input wire logic        ser_d2h,
  input wire logic        central_connect,
  input wire logic        central_disconnect,
  input wire logic        conn_event,
  input wire logic        air_tx_valid,
  input wire logic        advertising,
  input wire logic        peripheral_mode,
  input wire logic        central_role_allowed,
  input wire logic        adv_txpower_included,
  input wire logic [19:0] fixed_pairing_key,
  input wire logic        bonding_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_closed2;
    (!channel_open_indicator) [*2];
  endsequence
  sequence s_pkt_start;
    $rose(air_tx_valid);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_open_on;
    advertising && central_connect |=> channel_open_indicator && !advertising;
  endproperty
  property p_open_off;
    channel_open_indicator && central_disconnect
      |=> !channel_open_indicator && advertising;
  endproperty
  property p_adv_hold;
    advertising && !central_connect |=> advertising;
  endproperty
  // one cycle of slack: the line flop trails the indicator
  property p_line_idle;
    s_closed2 |-> ser_d2h;
  endproperty
  property p_no_central;
    peripheral_mode |-> !central_role_allowed;
  endproperty
  property p_no_txpwr;
    peripheral_mode |-> !adv_txpower_included;
  endproperty
  property p_key;
    fixed_pairing_key == 20'h1E0F3 && bonding_enabled;
  endproperty
  property p_adv_mode;
    advertising |-> peripheral_mode;
  endproperty
  property p_one_pkt;
    s_pkt_start |-> $past(conn_event, 2) || $past(conn_event, 3);
  endproperty
  property p_start_bit;
    $fell(ser_d2h) |=> (!ser_d2h) [*8];
  endproperty
  a_open_on: assert property (p_open_on)
    else $error("no open on connect");
  a_open_off: assert property (p_open_off)
    else $error("no close on disconnect");
  a_adv_hold: assert property (p_adv_hold)
    else $error("advertising dropped");
  a_line_idle: assert property (p_line_idle)
    else $error("line active while closed");
  a_no_central: assert property (p_no_central)
    else $error("central role allowed");
  a_no_txpwr: assert property (p_no_txpwr)
    else $error("tx power block advertised");
  a_key: assert property (p_key)
    else $error("pairing default wrong");
  a_adv_mode: assert property (p_adv_mode)
    else $error("advertising outside peripheral mode");
  a_one_pkt: assert property (p_one_pkt)
    else $error("packet without event");
  a_start_bit: assert property (p_start_bit)
    else $error("start bit too short");
endmodule

// >>> testbench/tb_top.sv
// self-checking bench: host controller and bridge end facing each other
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // gap longer than one byte time so a burst stays in one packet
  localparam int GAP = 12000;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pick;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [47:0] radio_mac_address;
  logic        central_connect, central_disconnect, mtu_req, conn_event;
  logic [7:0]  mtu_payload, air_rx_data, air_tx_data;
  logic        air_rx_valid, air_rx_ready, air_tx_valid, air_tx_last;
  logic        air_tx_ready, advertising, peripheral_mode, bonding_enabled;
  logic        central_role_allowed, adv_txpower_included;
  logic [63:0] adv_name;
  logic [19:0] fixed_pairing_key;
  logic [7:0]  peripheral_security_setting;
  logic [23:0] bytes;
  int          failures, n_compared, n;
  trb_if lnk_if ();
  wire logic line = pick ? lnk_if.ser_d2h : lnk_if.ser_h2d;
  trb_dev #(.IDLE_GAP(GAP)) trb_dev_i (
    .hclk, .hresetn, .lnk(lnk_if.dev), .radio_mac_address, .central_connect,
    .central_disconnect, .mtu_req, .mtu_payload, .conn_event, .air_rx_valid,
    .air_rx_data, .air_rx_ready, .air_tx_valid, .air_tx_data, .air_tx_last,
    .air_tx_ready, .advertising, .peripheral_mode, .central_role_allowed,
    .adv_txpower_included, .adv_name, .fixed_pairing_key,
    .peripheral_security_setting, .bonding_enabled);
  trb_host #(.IDLE_GAP(GAP)) trb_host_i (
    .hclk, .hresetn, .lnk(lnk_if.host), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp);
  trb_asserts trb_asserts_i (
    .hclk, .hresetn, .channel_open_indicator(lnk_if.channel_open_indicator),
    .ser_d2h(lnk_if.ser_d2h), .central_connect, .central_disconnect,
    .conn_event, .air_tx_valid, .advertising, .peripheral_mode,
    .central_role_allowed, .adv_txpower_included, .fixed_pairing_key,
    .bonding_enabled);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wait_stat(input int b, input logic v);
    int i;
    for (i = 0; i < 6000; i++) begin
      ahb(1'b0, 8'h04, 32'h0);
      if (r[b] === v) break;
    end
    if (i == 6000) failures++;
  endtask
  // k: 0 connect, 1 disconnect, 2 connection event, 3 size request
  task pulse(input int k);
    @(posedge hclk);
    case (k)
      0: central_connect <= 1'b1;
      1: central_disconnect <= 1'b1;
      2: conn_event <= 1'b1;
      default: mtu_req <= 1'b1;
    endcase
    @(posedge hclk);
    {central_connect, central_disconnect, conn_event, mtu_req} <= 4'h0;
    @(posedge hclk);
  endtask
  task low_len(input logic p);
    int i;
    pick = p;
    n = 0;
    for (i = 0; i < 20000 && line !== 1'b0; i++) @(posedge hclk);
    while (line === 1'b0 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task collect;
    n = 0;
    bytes = 24'h0;
    repeat (40) begin
      @(posedge hclk);
      if (air_tx_valid === 1'b1) begin
        bytes = {bytes[15:0], air_tx_data};
        n++;
      end
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_static;
    chk(peripheral_mode, 1'b1);
    chk(advertising, 1'b1);
    chk(central_role_allowed, 1'b0);
    chk(adv_txpower_included, 1'b0);
    chk(adv_name, 64'h412D454639413543);
    chk({bonding_enabled, fixed_pairing_key}, 21'h11E0F3);
    chk(peripheral_security_setting, 8'h0B);
    chk(air_rx_ready, 1'b0);
    ahb(1'b1, 8'h08, 32'h5A);
    repeat (1000) @(posedge hclk);
    ahb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_open;
    pulse(0);
    chk({lnk_if.channel_open_indicator, advertising}, 2'b10);
    mtu_payload <= 8'hF3;
    pulse(3);
    wait_stat(0, 1'b1);
  endtask
  task t_rx;
    fork
      begin
        @(posedge hclk);
        air_rx_valid <= 1'b1;
        air_rx_data <= 8'hA5;
        do @(posedge hclk); while (air_rx_ready !== 1'b1);
        air_rx_valid <= 1'b0;
      end
      low_len(1'b1);
    join
    chk(n, 868);
    wait_stat(2, 1'b1);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(r[7:0], 8'hA5);
  endtask
  task t_tx;
    fork
      ahb(1'b1, 8'h08, 32'hA5);
      low_len(1'b0);
    join
    chk(n, 868);
    wait_stat(1, 1'b0);
    ahb(1'b1, 8'h08, 32'h02);
    wait_stat(1, 1'b0);
    ahb(1'b1, 8'h08, 32'h7E);
    wait_stat(1, 1'b0);
    // still inside the idle gap: nothing may leave yet
    fork pulse(2); collect; join
    chk(n, 0);
    repeat (GAP) @(posedge hclk);
    fork pulse(2); collect; join
    chk(bytes, 24'hA5027E);
    chk(n, 3);
    fork pulse(2); collect; join
    chk(n, 0);
  endtask
  task t_close;
    pulse(1);
    chk({lnk_if.channel_open_indicator, advertising}, 2'b01);
    wait_stat(0, 1'b0);
    chk(air_rx_ready, 1'b0);
  endtask
  initial begin
    {hresetn, hsel, hwrite, pick, central_connect, central_disconnect} = 6'h0;
    {mtu_req, conn_event, air_rx_valid} = 3'h0;
    {haddr, hwdata, htrans, mtu_payload, air_rx_data} = 82'h0;
    hsize = 3'h2;
    air_tx_ready = 1'b1;
    radio_mac_address = 48'h0012_34EF_9A5C;
    {failures, n_compared} = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    t_static;
    t_open;
    t_rx;
    t_tx;
    t_close;
    tally_and_finish;
  end
  initial begin
    repeat (95000) @(posedge hclk);
    failures++;
    tally_and_finish;
  end
endmodule
